// ===== hw/tpg_pkg.sv
// Package with register map, field layouts and types of the test pattern block
package tpg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] TPG_IDX_CONFIG0 = 8'h00;
  localparam logic [7:0] TPG_IDX_VSTART_HI = 8'h2a;
  localparam logic [7:0] TPG_IDX_VSTART_LO = 8'h2b;
  localparam logic [7:0] TPG_IDX_VWIDTH_HI = 8'h2c;
  localparam logic [7:0] TPG_IDX_VWIDTH_LO = 8'h2d;
  localparam logic [7:0] TPG_IDX_MODE = 8'h38;
  localparam logic [7:0] TPG_IDX_PITCH = 8'h39;
  localparam logic [7:0] TPG_IDX_STEP = 8'h3a;
  localparam logic [7:0] TPG_IDX_BASE_HI = 8'h3b;
  localparam logic [7:0] TPG_IDX_BASE_LO = 8'h3c;
  localparam logic [7:0] TPG_IDX_STAGGER = 8'h3d;
  localparam logic [7:0] TPG_IDX_STATUS = 8'h3e;
  localparam logic [7:0] TPG_IDX_SMODE = 8'h3f;
  // Field positions
  localparam int TPG_CFG0_CORR_BIT = 0;
  localparam int TPG_CFG0_MON_BIT = 1;
  localparam int TPG_MODE_EN_BIT = 0;
  localparam int TPG_MODE_KIND_LSB = 1;
  localparam int TPG_MODE_COLOR_LSB = 3;
  localparam int TPG_MODE_REFSEL_BIT = 5;
  // Values after reset, and the top pixel code
  localparam logic [7:0] TPG_RST_BYTE = 8'h00;
  localparam logic [7:0] TPG_RST_PITCH = 8'h01;
  localparam logic [2:0] TPG_RST_SMODE = 3'h0;
  localparam logic [9:0] TPG_CODE_MAX = 10'h3ff;
  localparam logic [15:0] TPG_RST_COUNT = 16'h0000;

  typedef enum logic [1:0] {
    TPG_KIND_FIXED = 2'b00,
    TPG_KIND_HGRAD = 2'b01,
    TPG_KIND_VGRAD = 2'b10,
    TPG_KIND_LATTICE = 2'b11
  } tpg_kind_t;

  typedef enum logic [1:0] {
    TPG_COL_ALL = 2'b00,
    TPG_COL_RED = 2'b01,
    TPG_COL_GREEN = 2'b10,
    TPG_COL_BLUE = 2'b11
  } tpg_color_t;

  typedef enum logic [2:0] {
    TPG_SM_SELF_PHASED_HOLD = 3'b000,
    TPG_SM_DIRECT_HOLD = 3'b001,
    TPG_SM_PHASE_CLOCKED_HOLD = 3'b010,
    TPG_SM_GATED_HOLD = 3'b011,
    TPG_SM_PHASE_CLOCKED_CORR = 3'b100,
    TPG_SM_GATED_CORR = 3'b101
  } tpg_smode_t;

  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } tpg_pix_t;

  typedef struct packed {
    logic clamp;
    logic sample;
    logic second_sample_n;
  } tpg_strobe_t;
endpackage : tpg_pkg

// ===== hw/tpg_top.sv
// Output test pattern generator and timing monitor with APB register access
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Pattern codes replace pixel data only while pattern_enable is set.
// - Kind select: 00 fixed, 01 horizontal, 10 vertical, 11 lattice.
// - Color select: 00 all, 01 red, 10 green, 11 blue.
// - With one color selected, the other colors output code 1023.
// - Window starts a programmed pixel count after the chosen reference edge.
// - Window lasts a programmed number of pixels from its start.
// - Base level 0..1023 is output throughout the window in fixed mode.
// - Both gradations begin with the base level code.
// - Lattice outputs base level except marker pixels and marker lines.
// - Pitch sets the interval in pixels or lines between code steps.
// - Step is the code increment added once per pitch interval.
// - Stagger delays start red to green and green to blue, fixed order.
// - Stagger zero switches all colors in the same line.
// - Stagger applies only when the enable is set, not again while running.
// - Config0 bit 1 enables timing monitor on two output bits.
// - Correlated: sample bit 2, reference bit 3; gated/phased hold: sample both.
// - Direct hold modes: sample bit 2, active-low second stage on bit 3.
// - Horizontal steps every pitch pixels, wraps to base, repeats each line.
// - Vertical holds code per line, steps every pitch lines, wraps to base.
// - Marker lines output step; others one step pixel then pitch-1 base.
// - Generation runs without break until the enable is cleared.
module tpg_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the sensor timing side
  input wire logic line_sync_in,
  input wire logic black_clamp_input,
  input wire logic pixel_strobe,
  // Converted pixel data and internal strobes, same clock
  input wire tpg_pkg::tpg_pix_t pixel_in,
  input wire tpg_pkg::tpg_strobe_t strobe_in,
  // Output bus
  output tpg_pkg::tpg_pix_t pixel_output_bus,
  output logic pixel_out_valid
);
  import tpg_pkg::*;

  // Register file
  logic [7:0] config0_reg;
  logic [7:0] vstart_hi_reg, vstart_lo_reg, vwidth_hi_reg, vwidth_lo_reg;
  logic [7:0] mode_reg, pitch_reg, step_reg, base_hi_reg, base_lo_reg, stagger_reg;
  logic [7:0] smode_reg;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pslverr_reg, pslverr_next;

  // APB decode
  wire access_w = psel & penable;
  wire xfer_done = access_w & pready_reg;
  wire [7:0] idx = paddr[9:2];
  wire aligned = (paddr[1:0] == 2'b00) & (paddr[11:10] == 2'b00);
  wire wr_en = xfer_done & pwrite & aligned;
  wire [7:0] wbyte = pwdata[7:0];

  // Synchronisers for pin inputs
  logic [1:0] lsync_ff, bclamp_ff, pstb_ff;
  logic ref_last_reg, pstb_last_reg;

  // Pattern engine state
  logic [15:0] pix_cnt_reg;
  logic [7:0] hpit_cnt_reg, lpit_cnt_reg;
  logic [15:0] line_cnt_reg;
  logic [9:0] hcode_reg, vcode_reg;
  logic running_reg;
  logic line_seen_reg;
  logic [2:0] col_on_reg;
  logic in_win_reg;
  tpg_pix_t out_reg;
  logic out_valid_reg;

  // Decoded settings
  wire pat_en = mode_reg[TPG_MODE_EN_BIT];
  wire tpg_kind_t kind = tpg_kind_t'(mode_reg[TPG_MODE_KIND_LSB +: 2]);
  wire tpg_color_t colsel = tpg_color_t'(mode_reg[TPG_MODE_COLOR_LSB +: 2]);
  wire ref_sel = mode_reg[TPG_MODE_REFSEL_BIT];
  wire monitor_on = config0_reg[TPG_CFG0_MON_BIT];
  wire tpg_smode_t smode = tpg_smode_t'(smode_reg[2:0]);
  wire [15:0] vstart = {vstart_hi_reg, vstart_lo_reg};
  wire [15:0] vwidth = {vwidth_hi_reg, vwidth_lo_reg};
  wire [9:0] base_lvl = {base_hi_reg[1:0], base_lo_reg};
  wire [9:0] step_code = {2'b00, step_reg};
  // A pitch of zero would never step; treat it as one
  wire [7:0] pitch = (pitch_reg == 8'h00) ? 8'h01 : pitch_reg;

  // Pitch counters wrap at pitch-1
  function automatic logic [7:0] tpg_pitch_next(input logic [7:0] cnt, input logic [7:0] p);
    tpg_pitch_next = (cnt >= p - 8'h01) ? 8'h00 : cnt + 8'h01;
  endfunction : tpg_pitch_next

  // Code increment that restarts from base once past the top code
  function automatic logic [9:0] tpg_code_step(input logic [9:0] code, input logic [9:0] stp,
                                               input logic [9:0] base);
    logic [10:0] sum;
    sum = {1'b0, code} + {1'b0, stp};
    tpg_code_step = (sum > {1'b0, TPG_CODE_MAX}) ? base : sum[9:0];
  endfunction : tpg_code_step

  // Reference edge and pixel tick detection on synchronised levels
  wire ref_lvl = ref_sel ? bclamp_ff[1] : lsync_ff[1];
  wire ref_rise = ref_lvl & ~ref_last_reg;
  wire pix_tick = pstb_ff[1] & ~pstb_last_reg;
  wire [16:0] win_end = {1'b0, vstart} + {1'b0, vwidth};
  wire win_now = ({1'b0, pix_cnt_reg} >= {1'b0, vstart}) &
                 ({1'b0, pix_cnt_reg} < win_end);
  wire win_first = win_now & (pix_cnt_reg == vstart);
  wire en_rise = pat_en & ~running_reg;

  // Stagger: lines after start at which green and blue join
  wire [15:0] green_line = {8'h00, stagger_reg};
  wire [16:0] blue_sum = {9'h000, stagger_reg} + {9'h000, stagger_reg};
  wire [15:0] blue_line = blue_sum[15:0];

  // Code of the current pixel for the chosen kind
  wire [7:0] hpit_now = win_first ? 8'h00 : hpit_cnt_reg;
  wire [9:0] hcode_now = win_first ? base_lvl : hcode_reg;
  logic [9:0] pat_code;
  always_comb begin
    case (kind)
      TPG_KIND_FIXED: pat_code = base_lvl;
      TPG_KIND_HGRAD: pat_code = hcode_now;
      TPG_KIND_VGRAD: pat_code = vcode_reg;
      TPG_KIND_LATTICE: begin
        pat_code = ((lpit_cnt_reg == 8'h00) || (hpit_now == 8'h00)) ? step_code : base_lvl;
      end
      default: pat_code = base_lvl;
    endcase
  end

  // Per-color selection; unselected colors are forced to the top code
  wire sel_r = (colsel == TPG_COL_ALL) | (colsel == TPG_COL_RED);
  wire sel_g = (colsel == TPG_COL_ALL) | (colsel == TPG_COL_GREEN);
  wire sel_b = (colsel == TPG_COL_ALL) | (colsel == TPG_COL_BLUE);
  // Enable gates directly, so clearing it stops the pattern at once
  wire pat_live = pat_en & running_reg & win_now;

  function automatic logic [9:0] tpg_lane(input logic live, input logic on, input logic sel,
                                          input logic [9:0] code, input logic [9:0] raw);
    if (!live || !on) begin
      tpg_lane = raw;
    end else if (sel) begin
      tpg_lane = code;
    end else begin
      tpg_lane = TPG_CODE_MAX;
    end
  endfunction : tpg_lane

  tpg_pix_t pat_pix;
  assign pat_pix.red = tpg_lane(pat_live, col_on_reg[0], sel_r, pat_code, pixel_in.red);
  assign pat_pix.green = tpg_lane(pat_live, col_on_reg[1], sel_g, pat_code, pixel_in.green);
  assign pat_pix.blue = tpg_lane(pat_live, col_on_reg[2], sel_b, pat_code, pixel_in.blue);

  // Timing monitor bits 3:2 per sample mode
  logic [1:0] mon_bits;
  always_comb begin
    case (smode)
      TPG_SM_PHASE_CLOCKED_CORR, TPG_SM_GATED_CORR: begin
        mon_bits = {strobe_in.clamp, strobe_in.sample};
      end
      TPG_SM_PHASE_CLOCKED_HOLD, TPG_SM_GATED_HOLD: begin
        mon_bits = {strobe_in.sample, strobe_in.sample};
      end
      TPG_SM_DIRECT_HOLD, TPG_SM_SELF_PHASED_HOLD: begin
        mon_bits = {strobe_in.second_sample_n, strobe_in.sample};
      end
      default: mon_bits = {strobe_in.sample, strobe_in.sample};
    endcase
  end

  tpg_pix_t out_next;
  assign out_next.red = monitor_on ? {pat_pix.red[9:4], mon_bits, pat_pix.red[1:0]}
                                   : pat_pix.red;
  assign out_next.green = monitor_on ? {pat_pix.green[9:4], mon_bits, pat_pix.green[1:0]}
                                     : pat_pix.green;
  assign out_next.blue = monitor_on ? {pat_pix.blue[9:4], mon_bits, pat_pix.blue[1:0]}
                                    : pat_pix.blue;

  // Next-state terms of the engine
  wire [16:0] pix_inc = {1'b0, pix_cnt_reg} + 17'h00001;
  wire [16:0] line_inc = {1'b0, line_cnt_reg} + 17'h00001;
  // First reference edge after enable opens line zero; later ones advance, saturating
  wire [15:0] line_now = (line_seen_reg & ~line_inc[16]) ? line_inc[15:0] : line_cnt_reg;
  wire h_wrap = (hpit_now >= pitch - 8'h01);
  wire l_wrap = (lpit_cnt_reg >= pitch - 8'h01);
  logic [2:0] col_on_next;
  always_comb begin
    col_on_next = col_on_reg;
    if (!pat_en) begin
      col_on_next = 3'b000;
    end else if (en_rise) begin
      col_on_next = 3'b001 | ((green_line == 16'h0000) ? 3'b110 : 3'b000);
    end else begin
      // Once a color has joined it stays on; stagger is not reapplied
      if (ref_rise && (line_now >= green_line)) col_on_next[1] = 1'b1;
      if (ref_rise && (line_now >= blue_line)) col_on_next[2] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsync_ff <= 2'b00;
      bclamp_ff <= 2'b00;
      pstb_ff <= 2'b00;
      ref_last_reg <= 1'b0;
      pstb_last_reg <= 1'b0;
    end else begin
      lsync_ff <= {lsync_ff[0], line_sync_in};
      bclamp_ff <= {bclamp_ff[0], black_clamp_input};
      pstb_ff <= {pstb_ff[0], pixel_strobe};
      ref_last_reg <= ref_lvl;
      pstb_last_reg <= pstb_ff[1];
    end
  end

  // Pixel position counter, restarted by each reference edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_cnt_reg <= TPG_RST_COUNT;
      in_win_reg <= 1'b0;
    end else if (ref_rise) begin
      pix_cnt_reg <= TPG_RST_COUNT;
      in_win_reg <= 1'b0;
    end else if (pix_tick) begin
      // Saturate so a long line does not fold back into the window
      pix_cnt_reg <= pix_inc[16] ? pix_cnt_reg : pix_inc[15:0];
      in_win_reg <= win_now;
    end
  end

  // Horizontal state: per-line restart, step every pitch pixels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hpit_cnt_reg <= TPG_RST_BYTE;
      hcode_reg <= 10'h000;
    end else if (pix_tick && win_now) begin
      hpit_cnt_reg <= tpg_pitch_next(hpit_now, pitch);
      hcode_reg <= h_wrap ? tpg_code_step(hcode_now, step_code, base_lvl) : hcode_now;
    end
  end

  // Line state: pitch in lines, vertical code, start and stagger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_reg <= 1'b0;
      line_seen_reg <= 1'b0;
      line_cnt_reg <= TPG_RST_COUNT;
      lpit_cnt_reg <= TPG_RST_BYTE;
      vcode_reg <= 10'h000;
    end else if (!pat_en) begin
      running_reg <= 1'b0;
      line_seen_reg <= 1'b0;
    end else if (en_rise) begin
      running_reg <= 1'b1;
      line_seen_reg <= 1'b0;
      line_cnt_reg <= TPG_RST_COUNT;
      lpit_cnt_reg <= TPG_RST_BYTE;
      vcode_reg <= base_lvl;
    end else if (ref_rise && !line_seen_reg) begin
      // First line keeps base code and marker phase
      line_seen_reg <= 1'b1;
    end else if (ref_rise) begin
      line_cnt_reg <= line_now;
      lpit_cnt_reg <= tpg_pitch_next(lpit_cnt_reg, pitch);
      vcode_reg <= l_wrap ? tpg_code_step(vcode_reg, step_code, base_lvl) : vcode_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_on_reg <= 3'b000;
      out_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      col_on_reg <= col_on_next;
      out_valid_reg <= pix_tick;
      if (pix_tick) begin
        out_reg <= out_next;
      end
    end
  end

  // APB read mux
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (idx)
      TPG_IDX_CONFIG0: rd_byte = config0_reg;
      TPG_IDX_VSTART_HI: rd_byte = vstart_hi_reg;
      TPG_IDX_VSTART_LO: rd_byte = vstart_lo_reg;
      TPG_IDX_VWIDTH_HI: rd_byte = vwidth_hi_reg;
      TPG_IDX_VWIDTH_LO: rd_byte = vwidth_lo_reg;
      TPG_IDX_MODE: rd_byte = mode_reg;
      TPG_IDX_PITCH: rd_byte = pitch_reg;
      TPG_IDX_STEP: rd_byte = step_reg;
      TPG_IDX_BASE_HI: rd_byte = {6'h00, base_hi_reg[1:0]};
      TPG_IDX_BASE_LO: rd_byte = base_lo_reg;
      TPG_IDX_STAGGER: rd_byte = stagger_reg;
      TPG_IDX_STATUS: rd_byte = {3'b000, in_win_reg, col_on_reg, running_reg};
      TPG_IDX_SMODE: rd_byte = {5'h00, smode_reg[2:0]};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  // Refused reads return zero, misaligned ones included
  wire [7:0] rd_safe = (rd_hit & aligned) ? rd_byte : 8'h00;
  assign prdata_next = (access_w & ~pready_reg & ~pwrite) ? {24'h000000, rd_safe} : prdata_reg;
  assign pslverr_next = access_w & ~pready_reg & ~(rd_hit & aligned);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      // One wait state lets read data and error come from flops
      pready_reg <= access_w & ~pready_reg;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config0_reg <= TPG_RST_BYTE;
      vstart_hi_reg <= TPG_RST_BYTE;
      vstart_lo_reg <= TPG_RST_BYTE;
      vwidth_hi_reg <= TPG_RST_BYTE;
      vwidth_lo_reg <= TPG_RST_BYTE;
      mode_reg <= TPG_RST_BYTE;
      pitch_reg <= TPG_RST_PITCH;
      step_reg <= TPG_RST_BYTE;
      base_hi_reg <= TPG_RST_BYTE;
      base_lo_reg <= TPG_RST_BYTE;
      stagger_reg <= TPG_RST_BYTE;
      smode_reg <= {5'h00, TPG_RST_SMODE};
    end else if (wr_en) begin
      case (idx)
        TPG_IDX_CONFIG0: config0_reg <= wbyte;
        TPG_IDX_VSTART_HI: vstart_hi_reg <= wbyte;
        TPG_IDX_VSTART_LO: vstart_lo_reg <= wbyte;
        TPG_IDX_VWIDTH_HI: vwidth_hi_reg <= wbyte;
        TPG_IDX_VWIDTH_LO: vwidth_lo_reg <= wbyte;
        TPG_IDX_MODE: mode_reg <= wbyte;
        TPG_IDX_PITCH: pitch_reg <= wbyte;
        TPG_IDX_STEP: step_reg <= wbyte;
        TPG_IDX_BASE_HI: base_hi_reg <= {6'h00, wbyte[1:0]};
        TPG_IDX_BASE_LO: base_lo_reg <= wbyte;
        TPG_IDX_STAGGER: stagger_reg <= wbyte;
        TPG_IDX_SMODE: smode_reg <= {5'h00, wbyte[2:0]};
        default: config0_reg <= config0_reg;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pixel_output_bus = out_reg;
  assign pixel_out_valid = out_valid_reg;
endmodule : tpg_top

`default_nettype wire

// ===== dv/tpg_checker.sv
// Port-level assertions for the test pattern block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module tpg_checker
  import tpg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pixel side
  input wire logic line_sync_in,
  input wire logic black_clamp_input,
  input wire logic pixel_strobe,
  input wire tpg_pkg::tpg_pix_t pixel_in,
  input wire tpg_pkg::tpg_strobe_t strobe_in,
  input wire tpg_pkg::tpg_pix_t pixel_output_bus,
  input wire logic pixel_out_valid
);
  logic en_q;
  logic mon_q;
  logic [2:0] sm_q;
  wire wr_done = psel && penable && pready && pwrite;
  // Shadow of the few settings the checks depend on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      mon_q <= 1'b0;
      sm_q <= 3'h0;
    end else if (wr_done) begin
      if (paddr == 12'h0e0) en_q <= pwdata[TPG_MODE_EN_BIT];
      if (paddr == 12'h000) mon_q <= pwdata[TPG_CFG0_MON_BIT];
      if (paddr == 12'h0fc) sm_q <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property ((psel && !penable) |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_misalign_err: assert property (psel && penable && pready && (paddr[1:0] != 2'b00)
    |-> pslverr) else $error("misaligned access not refused");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returns data");
  a_valid_single: assert property (pixel_out_valid |=> !pixel_out_valid)
    else $error("pixel valid longer than one cycle");
  a_bus_on_tick: assert property ($changed(pixel_output_bus) |-> pixel_out_valid)
    else $error("output bus moved between pixels");
  a_tick_lat: assert property ($rose(pixel_strobe) |-> ##[2:6] pixel_out_valid)
    else $error("pixel strobe gave no output");
  a_pass_thru: assert property (pixel_out_valid && !en_q && !$past(en_q) && !mon_q
    && !$past(mon_q) |-> pixel_output_bus == $past(pixel_in)) else $error("no pass-through");
  a_mon_corr: assert property (pixel_out_valid && mon_q && $past(mon_q) && $stable(sm_q)
    && sm_q[2] && !sm_q[1] |-> pixel_output_bus.red[3:2] ==
    {$past(strobe_in.clamp), $past(strobe_in.sample)}) else $error("monitor bits wrong");
  a_mon_direct: assert property (pixel_out_valid && mon_q && $past(mon_q) && $stable(sm_q)
    && sm_q[2:1] == 2'b00 |-> pixel_output_bus.red[3:2] ==
    {$past(strobe_in.second_sample_n), $past(strobe_in.sample)}) else $error("monitor bits wrong");
  a_mon_hold: assert property (pixel_out_valid && mon_q && $past(mon_q) && $stable(sm_q)
    && sm_q[2:1] == 2'b01 |-> pixel_output_bus.red[3:2] ==
    {2{$past(strobe_in.sample)}}) else $error("monitor bits wrong");
  c_write: cover property (wr_done);
  c_refused: cover property (pready && pslverr);
  c_monitor: cover property (pixel_out_valid && mon_q);
endmodule : tpg_checker

bind tpg_top tpg_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .line_sync_in(line_sync_in),
  .black_clamp_input(black_clamp_input), .pixel_strobe(pixel_strobe), .pixel_in(pixel_in),
  .strobe_in(strobe_in), .pixel_output_bus(pixel_output_bus),
  .pixel_out_valid(pixel_out_valid));
`default_nettype wire

// ===== dv/tpg_host_model.sv
// Host controller model capturing one line of pixels, one slot per pixel
`timescale 1ns/1ps
`default_nettype none
module tpg_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line start, restarts the slot index
  input wire logic line_clr,
  // Pixel stream
  input wire tpg_pkg::tpg_pix_t pix,
  input wire logic pix_valid
);
  import tpg_pkg::*;
  tpg_pix_t cap [0:15];
  logic [3:0] idx;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 4'h0;
    end else if (line_clr) begin
      idx <= 4'h0;
    end else if (pix_valid) begin
      cap[idx] <= pix;
      idx <= idx + 4'h1;
    end
  end
endmodule : tpg_host_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the test pattern block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tpg_pkg::*;
  localparam tpg_pix_t PIN = {10'h011, 10'h022, 10'h033};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic line_sync_in, black_clamp_input, pixel_strobe, pixel_out_valid, line_clr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  tpg_pix_t pixel_in, pixel_output_bus, mx;
  tpg_strobe_t strobe_in;
  logic [7:0] mode_v;
  logic [1:0] mb;
  int bad_count, cmp_count, cycles;
  logic [7:0] rm [0:5] = '{8'h01, 8'h09, 8'h11, 8'h19, 8'h00, 8'h21};
  tpg_pix_t rx [0:5] = '{30'h15555555, 30'h155fffff, 30'h3ff557ff, 30'h3ffffd55, PIN,
    30'h15555555};
  logic [9:0] hx [0:5] = '{10'h3f0, 10'h3f0, 10'h3f8, 10'h3f8, 10'h3f0, 10'h3f0};

  tpg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_sync_in(line_sync_in), .black_clamp_input(black_clamp_input),
    .pixel_strobe(pixel_strobe), .pixel_in(pixel_in), .strobe_in(strobe_in),
    .pixel_output_bus(pixel_output_bus), .pixel_out_valid(pixel_out_valid));
  tpg_host_model HOST (.pclk(pclk), .presetn(presetn), .line_clr(line_clr),
    .pix(pixel_output_bus), .pix_valid(pixel_out_valid));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Whole run needs about 3100 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  function automatic tpg_pix_t rep(input logic [9:0] c);
    return {c, c, c};
  endfunction : rep

  task chk(input string nm, input logic [29:0] exp, input logic [29:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) bad_count++;
  endtask : apb

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    chk("write_error", 30'h0, {29'h0, er});
  endtask : wr

  task rchk(input logic [11:0] a, input logic [7:0] e, input logic ee);
    apb(1'b0, a, 8'h00);
    chk("read_data", {22'h0, e}, rd[29:0]);
    chk("read_error", {29'h0, ee}, {29'h0, er});
  endtask : rchk

  // Pattern is stopped first so the 10-bit base never updates half-written
  task cfg(input logic [9:0] b, input logic [7:0] s, input logic [7:0] p, input logic [7:0] m);
    wr(12'h0e0, 8'h00);
    wr(12'h0ec, {6'h0, b[9:8]});
    wr(12'h0f0, b[7:0]);
    wr(12'h0e8, s);
    wr(12'h0e4, p);
    wr(12'h0e0, m);
    mode_v = m;
  endtask : cfg

  // Strobe phases of 4 cycles clear the 2-stage pin synchroniser
  task line(input int np);
    @(posedge pclk);
    line_clr <= 1'b1;
    if (mode_v[TPG_MODE_REFSEL_BIT]) black_clamp_input <= 1'b1;
    else line_sync_in <= 1'b1;
    repeat (4) @(posedge pclk);
    line_clr <= 1'b0;
    line_sync_in <= 1'b0;
    black_clamp_input <= 1'b0;
    repeat (4) @(posedge pclk);
    repeat (np) begin
      pixel_strobe <= 1'b1;
      repeat (4) @(posedge pclk);
      pixel_strobe <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask : line

  initial begin
    {psel, penable, pwrite, line_sync_in, black_clamp_input, pixel_strobe, line_clr} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pixel_in = PIN;
    strobe_in = 3'b000;
    mode_v = 8'h00;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h0e0, TPG_RST_BYTE, 1'b0);
    rchk(12'h0e4, TPG_RST_PITCH, 1'b0);
    rchk(12'h0a8, TPG_RST_BYTE, 1'b0);
    rchk(12'h040, 8'h00, 1'b1);
    apb(1'b1, 12'h0e1, 8'h05);
    chk("misaligned_error", 30'h1, {29'h0, er});
    wr(12'h0ac, 8'h02);
    wr(12'h0b4, 8'h06);
    rchk(12'h0b4, 8'h06, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      cfg(10'h155, 8'h00, 8'h01, rm[i]);
      line(9);
      chk("pixel_before", PIN, HOST.cap[1]);
      chk("pixel_first", rx[i], HOST.cap[2]);
      chk("pixel_last", rx[i], HOST.cap[7]);
      chk("pixel_after", PIN, HOST.cap[8]);
    end
    $display("test table done");
    cfg(10'h3f0, 8'h08, 8'h02, 8'h03);
    for (int ln = 0; ln < 2; ln++) begin
      line(9);
      for (int k = 0; k < 6; k++) chk("hgrad", rep(hx[k]), HOST.cap[2 + k]);
    end
    cfg(10'h300, 8'h80, 8'h01, 8'h05);
    for (int ln = 0; ln < 4; ln++) begin
      line(9);
      chk("vgrad", rep(ln[0] ? 10'h380 : 10'h300), HOST.cap[2]);
      chk("vgrad_hold", rep(ln[0] ? 10'h380 : 10'h300), HOST.cap[7]);
    end
    cfg(10'h010, 8'haa, 8'h03, 8'h07);
    for (int ln = 0; ln < 4; ln++) begin
      line(9);
      for (int k = 0; k < 6; k++)
        chk("lattice", rep((ln % 3 == 0 || k % 3 == 0) ? 10'h0aa : 10'h010),
          HOST.cap[2 + k]);
    end
    $display("test gradations done");
    wr(12'h0f4, 8'h02);
    cfg(10'h155, 8'h00, 8'h01, 8'h01);
    line(9);
    chk("stagger_first", {10'h155, PIN.green, PIN.blue}, HOST.cap[2]);
    rchk(12'h0f8, 8'h03, 1'b0);
    repeat (5) line(9);
    chk("stagger_all", rep(10'h155), HOST.cap[2]);
    rchk(12'h0f8, 8'h0f, 1'b0);
    wr(12'h0f4, 8'h05);
    line(9);
    chk("stagger_once", rep(10'h155), HOST.cap[2]);
    wr(12'h0f4, 8'h00);
    $display("test stagger done");
    cfg(10'h155, 8'h00, 8'h01, 8'h00);
    wr(12'h000, 8'h02);
    for (int s = 0; s < 3; s++) begin
      for (int m = 0; m < 6; m++) begin
        wr(12'h0fc, m[7:0]);
        strobe_in <= (s == 0) ? 3'b100 : ((s == 1) ? 3'b001 : 3'b010);
        line(3);
        mb = (s == 0) ? ((m >= 4) ? 2'b10 : 2'b00) : (s == 1) ? ((m <= 1) ? 2'b10 : 2'b00)
          : ((m == 2 || m == 3) ? 2'b11 : 2'b01);
        mx = PIN;
        mx.red[3:2] = mb;
        mx.green[3:2] = mb;
        mx.blue[3:2] = mb;
        chk("monitor", mx, HOST.cap[1]);
      end
    end
    $display("test monitor done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset_bus", 30'h0, pixel_output_bus);
    rchk(12'h000, TPG_RST_BYTE, 1'b0);
    rchk(12'h0e4, TPG_RST_PITCH, 1'b0);
    rchk(12'h0f8, TPG_RST_BYTE, 1'b0);
    wr(12'h000, 8'h00);
    $display("test reset done");
    results();
  end
endmodule : testbench
`default_nettype wire
